// File: cyclic_axis_error_compensator.sv
// Overview of operation
// - One error cycle splits into a set number of steps, 128 at most.
// - Compensate only when enable setting is 1 and the option is present.
// - Axes under programmable logic control get no cyclic correction.
// - Needs rotary flag, screw pitch 360, division count 360 or 0.
// - Between step points, interpolate linearly between the two neighbouring steps.
// - Same step table serves every cycle; cycles per turn from cycle constant.
// - Each table entry is an absolute correction at its step.
// - Steps come from consecutive locations from start number over division count.
// - Table sits in shared locations 4101 to 5999 and 44001 to 47712.
// - Correction values count in ten-thousandths of a degree.
// - Cycle phase taken from position relative to machine zero.
// - Table edits act on the next computed position at once.
// - Correction stays zero until the axis zero point is established.
// - Last location (start plus divisions minus one) past 5999 disables compensation unless the table lies in 44001 to 47712.
// - Cyclic and pitch error corrections apply together on the axis.
`timescale 1ns/1ps
module cyclic_axis_error_compensator
  import cyc_comp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        ce_i,
  input  axi_req_t         axi_i,
  output axi_rsp_t         axi_o,
  input  wire logic        option_present_i,
  input  wire logic        nc_axis_i,
  input  wire logic        zero_established_i,
  input  wire logic        pos_valid_i,
  input  wire logic [31:0] pos_i,
  input  wire logic [31:0] pitch_corr_i,
  output logic             pos_ready_o,
  output logic             out_valid_o,
  output logic [31:0]      pos_o,
  output logic [31:0]      corr_o,
  output logic             active_o
);

  typedef struct packed {
    logic                                aw_held;
    logic [ADDR_W-1:0]                   aw_addr;
    logic                                w_held;
    logic [31:0]                         w_data;
    logic [3:0]                          w_strb;
    logic                                bvalid;
    logic [1:0]                          bresp;
    logic                                rvalid;
    logic [31:0]                         rdata;
    logic [1:0]                          rresp;
    logic [7:0]                          enable_setting;
    logic                                rotary_flag;
    logic [15:0]                         screw_pitch;
    logic [15:0]                         rotary_division_count;
    logic [15:0]                         start_num;
    logic [7:0]                          num_div;
    logic [15:0]                         cycle_const;
    logic [MAX_STEPS-1:0][CORR_W-1:0]    table_mem;
    calc_state_t                         state;
    logic                                neg;
    logic                                dneg;
    logic [CORR_W-1:0]                   a0;
    logic [DIV_W-1:0]                    work;
    logic                                div_start;
    logic [31:0]                         pos;
    logic [31:0]                         pos_out;
    logic [31:0]                         corr_out;
    logic                                out_valid;
    logic                                active;
    logic                                range_ok;
  } core_state_t;

  core_state_t      s;
  core_state_t      next_s;
  logic             div_done;
  logic [DIV_W-1:0] div_quot;
  logic [DIV_W-1:0] div_rem;
  logic             range_ok;
  logic             axis_ok;
  logic             active;
  logic [16:0]      last_loc;

  cyc_divider u_div (
    .clk_i      (clk_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .start_i    (s.div_start),
    .dividend_i (s.work),
    .divisor_i  (FULL_TURN_UNITS),
    .done_o     (div_done),
    .quot_o     (div_quot),
    .rem_o      (div_rem)
  );

  // Applies byte strobes over the current register value
  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : apply_strb

  // Returns {hit, value} for a register address
  function automatic logic [32:0] reg_read(input core_state_t st,
                                           input logic [ADDR_W-1:0] a);
    logic [31:0] v;
    logic        hit;
    v   = '0;
    hit = 1'b1;
    if (a == OFS_CTRL) begin
      v[7:0] = st.enable_setting;
    end else if (a == OFS_ROTARY) begin
      v[0] = st.rotary_flag;
    end else if (a == OFS_PITCH) begin
      v[15:0] = st.screw_pitch;
    end else if (a == OFS_ROT_DIV) begin
      v[15:0] = st.rotary_division_count;
    end else if (a == OFS_START) begin
      v[15:0] = st.start_num;
    end else if (a == OFS_NUM_DIV) begin
      v[7:0] = st.num_div;
    end else if (a == OFS_CYC_CONST) begin
      v[15:0] = st.cycle_const;
    end else if (a == OFS_STATUS) begin
      v[STAT_ACTIVE] = st.active;
      v[STAT_RANGE]  = st.range_ok;
      v[STAT_BUSY]   = (st.state != ST_IDLE);
    end else if (a == OFS_CORR) begin
      v = st.corr_out;
    end else if (a >= OFS_TABLE && a <= OFS_TABLE_END) begin
      v = {{(32-CORR_W){st.table_mem[a[IDX_W+1:2]][CORR_W-1]}},
           st.table_mem[a[IDX_W+1:2]]};
    end else begin
      hit = 1'b0;
    end
    return {hit, v};
  endfunction : reg_read

  // Enabling conditions
  always_comb begin
    last_loc = {1'b0, s.start_num} + {9'h000, s.num_div} - 17'h00001;
    range_ok = (s.num_div != 8'h00) && (s.num_div <= MAX_DIV) &&
               (({1'b0, s.start_num} >= LOC_LOW_FIRST && last_loc <= LOC_LOW_LAST) ||
                ({1'b0, s.start_num} >= LOC_HIGH_FIRST &&
                 last_loc <= LOC_HIGH_LAST));
    axis_ok  = s.rotary_flag && (s.screw_pitch == ROT_PITCH) &&
               (s.rotary_division_count == ROT_DIV_A ||
                s.rotary_division_count == ROT_DIV_B);
    active   = (s.enable_setting == CYC_ENABLE_ON) && option_present_i &&
               nc_axis_i &&
               zero_established_i &&
               axis_ok && range_ok && (s.cycle_const != 16'h0000);
  end

  always_comb begin
    logic [32:0]       rd;
    logic [32:0]       wr_old;
    logic [31:0]       wv;
    logic [31:0]       pos_mag;
    logic [DIV_W-1:0]  turn_rem;
    logic [IDX_W-1:0]  idx;
    logic [IDX_W-1:0]  nidx;
    logic [CORR_W-1:0] a1;
    logic [CORR_W:0]   delta;
    logic [CORR_W:0]   dmag;
    logic [31:0]       a0x;
    logic [31:0]       frac;
    logic [31:0]       corr;
    rd       = '0;
    wr_old   = '0;
    wv       = '0;
    pos_mag  = '0;
    turn_rem = '0;
    idx      = '0;
    nidx     = '0;
    a1       = '0;
    delta    = '0;
    dmag     = '0;
    a0x      = '0;
    frac     = '0;
    corr     = '0;
    next_s   = s;
    next_s.out_valid = 1'b0;
    next_s.div_start = 1'b0;
    next_s.active    = active;
    next_s.range_ok  = range_ok;

    // Write address and data, taken in either order
    if (axi_i.awvalid && !s.aw_held && !s.bvalid) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = axi_i.awaddr[ADDR_W-1:0];
    end
    if (axi_i.wvalid && !s.w_held && !s.bvalid) begin
      next_s.w_held = 1'b1;
      next_s.w_data = axi_i.wdata;
      next_s.w_strb = axi_i.wstrb;
    end
    if (s.aw_held && s.w_held && !s.bvalid) begin
      wr_old = reg_read(s, s.aw_addr);
      wv     = apply_strb(wr_old[31:0], s.w_data, s.w_strb);
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = wr_old[32] ? RESP_OKAY : RESP_SLVERR;
      if (s.aw_addr == OFS_CTRL) begin
        next_s.enable_setting = wv[7:0];
      end else if (s.aw_addr == OFS_ROTARY) begin
        next_s.rotary_flag = wv[0];
      end else if (s.aw_addr == OFS_PITCH) begin
        next_s.screw_pitch = wv[15:0];
      end else if (s.aw_addr == OFS_ROT_DIV) begin
        next_s.rotary_division_count = wv[15:0];
      end else if (s.aw_addr == OFS_START) begin
        next_s.start_num = wv[15:0];
      end else if (s.aw_addr == OFS_NUM_DIV) begin
        next_s.num_div = wv[7:0];
      end else if (s.aw_addr == OFS_CYC_CONST) begin
        next_s.cycle_const = wv[15:0];
      end else if (s.aw_addr >= OFS_TABLE && s.aw_addr <= OFS_TABLE_END) begin
        next_s.table_mem[s.aw_addr[IDX_W+1:2]] = wv[CORR_W-1:0];
      end
    end
    if (s.bvalid && axi_i.bready) begin
      next_s.bvalid = 1'b0;
    end

    // Read channel
    if (axi_i.arvalid && !s.rvalid) begin
      rd = reg_read(s, axi_i.araddr[ADDR_W-1:0]);
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd[31:0];
      next_s.rresp  = rd[32] ? RESP_OKAY : RESP_SLVERR;
    end
    if (s.rvalid && axi_i.rready) begin
      next_s.rvalid = 1'b0;
    end

    // Correction pipeline over the shared divider
    case (s.state)
      ST_IDLE: begin
        if (pos_valid_i) begin
          next_s.pos = pos_i;
          if (active) begin
            pos_mag          = pos_i[31] ? (32'h0 - pos_i) : pos_i;
            next_s.neg       = pos_i[31];
            next_s.work      = DIV_W'(pos_mag);
            next_s.div_start = 1'b1;
            next_s.state     = ST_TURN;
          end else begin
            next_s.corr_out  = '0;
            next_s.pos_out   = pos_i + pitch_corr_i;
            next_s.out_valid = 1'b1;
          end
        end
      end
      ST_TURN: begin
        if (div_done) begin
          turn_rem = div_rem;
          if (s.neg && div_rem != '0) begin
            turn_rem = FULL_TURN_UNITS - div_rem;
          end
          next_s.work      = turn_rem * DIV_W'(s.cycle_const);
          next_s.div_start = 1'b1;
          next_s.state     = ST_CYCLE;
        end
      end
      ST_CYCLE: begin
        if (div_done) begin
          next_s.work      = div_rem * DIV_W'(s.num_div);
          next_s.div_start = 1'b1;
          next_s.state     = ST_STEP;
        end
      end
      ST_STEP: begin
        if (div_done) begin
          idx   = div_quot[IDX_W-1:0];
          nidx  = ({1'b0, idx} + 8'h01 == s.num_div) ? '0 : (idx + IDX_W'(1));
          a1    = s.table_mem[nidx];
          delta = {a1[CORR_W-1], a1} -
                  {s.table_mem[idx][CORR_W-1], s.table_mem[idx]};
          dmag  = delta[CORR_W] ? ((CORR_W+1)'(0) - delta) : delta;
          next_s.a0        = s.table_mem[idx];
          next_s.dneg      = delta[CORR_W];
          next_s.work      = DIV_W'(dmag) * div_rem;
          next_s.div_start = 1'b1;
          next_s.state     = ST_INTERP;
        end
      end
      ST_INTERP: begin
        if (div_done) begin
          a0x  = {{(32-CORR_W){s.a0[CORR_W-1]}}, s.a0};
          frac = div_quot[31:0];
          corr = s.dneg ? (a0x - frac) : (a0x + frac);
          if (!active) begin
            corr = '0;
          end
          next_s.corr_out  = corr;
          next_s.pos_out   = s.pos + pitch_corr_i + corr;
          next_s.out_valid = 1'b1;
          next_s.state     = ST_IDLE;
        end
      end
      default: begin
        next_s.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s <= '0;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  always_comb begin
    axi_o         = '0;
    axi_o.awready = !s.aw_held && !s.bvalid;
    axi_o.wready  = !s.w_held && !s.bvalid;
    axi_o.bvalid  = s.bvalid;
    axi_o.bresp   = s.bresp;
    axi_o.arready = !s.rvalid;
    axi_o.rvalid  = s.rvalid;
    axi_o.rdata   = s.rdata;
    axi_o.rresp   = s.rresp;
  end

  assign pos_ready_o = (s.state == ST_IDLE);
  assign out_valid_o = s.out_valid;
  assign pos_o       = s.pos_out;
  assign corr_o      = s.corr_out;
  assign active_o    = s.active;

endmodule : cyclic_axis_error_compensator

// File: cyc_comp_pkg.sv
package cyc_comp_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DIV_W  = 48;
  localparam int unsigned CNT_W  = 6;

  // Table geometry
  localparam int unsigned        MAX_STEPS  = 128;
  localparam int unsigned        IDX_W      = 7;
  localparam int unsigned        CORR_W     = 16;
  localparam logic [7:0]         MAX_DIV    = 8'h80;

  // Angle units: one ten-thousandth of a degree
  localparam int unsigned        DEG_UNITS       = 32'h2710;
  localparam int unsigned        FULL_TURN_DEG   = 32'h168;
  localparam logic [DIV_W-1:0]   FULL_TURN_UNITS = DIV_W'(FULL_TURN_DEG * DEG_UNITS);

  // Axis configuration that permits compensation
  localparam logic [7:0]         CYC_ENABLE_ON = 8'h01;
  localparam logic [15:0]        ROT_PITCH     = 16'h0168;
  localparam logic [15:0]        ROT_DIV_A     = 16'h0168;
  localparam logic [15:0]        ROT_DIV_B     = 16'h0000;

  // Shared parameter storage location ranges
  localparam logic [16:0]        LOC_LOW_FIRST  = 17'h01005;
  localparam logic [16:0]        LOC_LOW_LAST   = 17'h0176F;
  localparam logic [16:0]        LOC_HIGH_FIRST = 17'h0ABE1;
  localparam logic [16:0]        LOC_HIGH_LAST  = 17'h0BA60;

  // Register byte offsets
  localparam logic [ADDR_W-1:0]  OFS_CTRL     = 12'h000;
  localparam logic [ADDR_W-1:0]  OFS_ROTARY   = 12'h004;
  localparam logic [ADDR_W-1:0]  OFS_PITCH    = 12'h008;
  localparam logic [ADDR_W-1:0]  OFS_ROT_DIV  = 12'h00C;
  localparam logic [ADDR_W-1:0]  OFS_START    = 12'h010;
  localparam logic [ADDR_W-1:0]  OFS_NUM_DIV  = 12'h014;
  localparam logic [ADDR_W-1:0]  OFS_CYC_CONST = 12'h018;
  localparam logic [ADDR_W-1:0]  OFS_STATUS   = 12'h01C;
  localparam logic [ADDR_W-1:0]  OFS_CORR     = 12'h020;
  localparam logic [ADDR_W-1:0]  OFS_TABLE    = 12'h400;
  localparam logic [ADDR_W-1:0]  OFS_TABLE_END = 12'h5FC;

  // Status field positions
  localparam int unsigned        STAT_ACTIVE = 0;
  localparam int unsigned        STAT_RANGE  = 1;
  localparam int unsigned        STAT_BUSY   = 2;

  localparam logic [1:0]         RESP_OKAY   = 2'h0;
  localparam logic [1:0]         RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_TURN   = 3'b001,
    ST_CYCLE  = 3'b010,
    ST_STEP   = 3'b011,
    ST_INTERP = 3'b100
  } calc_state_t;

  typedef struct packed {
    logic             busy;
    logic             done;
    logic [CNT_W-1:0] count;
    logic [DIV_W:0]   rem;
    logic [DIV_W-1:0] quot;
    logic [DIV_W-1:0] divisor;
  } div_state_t;

endpackage : cyc_comp_pkg

// File: cyc_divider.sv
`timescale 1ns/1ps
module cyc_divider
  import cyc_comp_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             ce_i,
  input  wire logic             start_i,
  input  wire logic [DIV_W-1:0] dividend_i,
  input  wire logic [DIV_W-1:0] divisor_i,
  output logic                  done_o,
  output logic [DIV_W-1:0]      quot_o,
  output logic [DIV_W-1:0]      rem_o
);

  div_state_t s;
  div_state_t next_s;

  // Restoring divider, one quotient bit per cycle
  always_comb begin
    logic [DIV_W:0]   trial;
    logic [DIV_W-1:0] q;
    trial  = '0;
    q      = '0;
    next_s = s;
    next_s.done = 1'b0;
    if (start_i && !s.busy) begin
      next_s.busy    = 1'b1;
      next_s.count   = CNT_W'(DIV_W);
      next_s.quot    = dividend_i;
      next_s.rem     = '0;
      next_s.divisor = divisor_i;
    end else if (s.busy) begin
      trial = {s.rem[DIV_W-1:0], s.quot[DIV_W-1]};
      q     = {s.quot[DIV_W-2:0], 1'b0};
      if (trial >= {1'b0, s.divisor}) begin
        trial = trial - {1'b0, s.divisor};
        q[0]  = 1'b1;
      end
      next_s.rem   = trial;
      next_s.quot  = q;
      next_s.count = s.count - CNT_W'(1);
      if (s.count == CNT_W'(1)) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s <= '0;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign done_o = s.done;
  assign quot_o = s.quot;
  assign rem_o  = s.rem[DIV_W-1:0];

endmodule : cyc_divider

// File: cyclic_axis_error_compensator_properties.sv
`timescale 1ns/1ps
module cyclic_axis_error_compensator_properties
  import cyc_comp_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic        ce_i,
  input axi_req_t         axi_i,
  input axi_rsp_t         axi_o,
  input wire logic        option_present_i,
  input wire logic        nc_axis_i,
  input wire logic        zero_established_i,
  input wire logic        pos_valid_i,
  input wire logic [31:0] pos_i,
  input wire logic [31:0] pitch_corr_i,
  input wire logic        pos_ready_o,
  input wire logic        out_valid_o,
  input wire logic [31:0] pos_o,
  input wire logic [31:0] corr_o,
  input wire logic        active_o
);
  logic [31:0] pos_lat;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i || !ce_i);
  // Position accepted by the last handshake
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pos_lat <= 32'h0;
    end else if (ce_i && pos_valid_i && pos_ready_o) begin
      pos_lat <= pos_i;
    end
  end
  active_cond_a: assert property (active_o |-> $past(option_present_i)
    && $past(nc_axis_i) && $past(zero_established_i)) else $error("active without enables");
  no_zero_corr_a: assert property (
    out_valid_o && !$past(zero_established_i) |-> corr_o == 32'h0) else $error("corr before zero");
  plc_axis_zero_a: assert property (
    out_valid_o && !$past(nc_axis_i) |-> corr_o == 32'h0) else $error("corr on plc axis");
  sum_output_a: assert property (
    out_valid_o |-> pos_o == pos_lat + $past(pitch_corr_i) + corr_o) else $error("bad pos sum");
  pos_answer_a: assert property (
    pos_valid_i && pos_ready_o |-> ##[1:260] out_valid_o) else $error("no position result");
  ready_after_a: assert property (out_valid_o |-> pos_ready_o) else $error("not ready");
  rd_answer_a: assert property (axi_i.arvalid && axi_o.arready |=> axi_o.rvalid)
    else $error("late read data");
  wr_answer_a: assert property (axi_i.awvalid && axi_o.awready && axi_i.wvalid
    && axi_o.wready |-> ##[1:2] axi_o.bvalid) else $error("late write response");
  rd_err_data_a: assert property (axi_o.rvalid && axi_o.rresp == RESP_SLVERR
    |-> axi_o.rdata == 32'h0) else $error("error read carries data");
  cover property (out_valid_o && corr_o != 32'h0);
  cover property (axi_o.bvalid && axi_o.bresp == RESP_SLVERR);
  cover property (active_o && pos_valid_i && pos_ready_o);
endmodule : cyclic_axis_error_compensator_properties

bind cyclic_axis_error_compensator cyclic_axis_error_compensator_properties u_props (
  .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .axi_i(axi_i), .axi_o(axi_o),
  .option_present_i(option_present_i), .nc_axis_i(nc_axis_i),
  .zero_established_i(zero_established_i), .pos_valid_i(pos_valid_i), .pos_i(pos_i),
  .pitch_corr_i(pitch_corr_i), .pos_ready_o(pos_ready_o), .out_valid_o(out_valid_o),
  .pos_o(pos_o), .corr_o(corr_o), .active_o(active_o));

// File: axis_feed_model.sv
`timescale 1ns/1ps
module axis_feed_model (
  input  wire logic        clk_i,
  input  wire logic        ready_i,
  input  wire logic        done_i,
  input  wire logic [31:0] res_pos_i,
  input  wire logic [31:0] res_corr_i,
  output logic             valid_o,
  output logic [31:0]      pos_o,
  output logic [31:0]      pitch_o
);
  initial begin
    valid_o = 1'b0;
    pos_o = 32'h0;
    pitch_o = 32'h0;
  end
  // Holds the sample until taken, the pitch term until the result
  task automatic send(input int gap, input logic [31:0] p, input logic [31:0] pc,
                      output logic [31:0] rp, output logic [31:0] rc);
    repeat (gap) @(posedge clk_i);
    valid_o <= 1'b1;
    pos_o <= p;
    pitch_o <= pc;
    do @(posedge clk_i); while (ready_i !== 1'b1);
    valid_o <= 1'b0;
    pos_o <= ~p;
    do @(posedge clk_i); while (done_i !== 1'b1);
    pitch_o <= ~pc;
    rp = res_pos_i;
    rc = res_corr_i;
  endtask : send
endmodule : axis_feed_model

// File: cyclic_axis_error_compensator_tb.sv
`timescale 1ns/1ps
module cyclic_axis_error_compensator_tb
  import cyc_comp_pkg::*;
;
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin fails++; \
  $display("[ERR] %s exp=%h got=%h", nm, ex, gt); end end
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        ce_i = 1'b1;
  axi_req_t    axi = '{bready: 1'b1, rready: 1'b1, default: '0};
  axi_rsp_t    axo;
  logic        opt = 1'b1;
  logic        nc = 1'b1;
  logic        zero = 1'b1;
  logic        pv, pr, ov, act;
  logic [31:0] pp, pc, po, co;
  int          fails = 0;
  int          n_tests = 0;
  int          nd = 0;
  int          cc = 0;
  int          tbl [128] = '{default: 0};
  int          init_tbl [8] = '{0, -2, -1, -3, 0, 1, 1, 2};
  int          pos_list [7] = '{0, 1000, 7031, 14062, 3601000, -5000, 3599999};

  always #5 clk_i = ~clk_i;

  cyclic_axis_error_compensator u_cyclic_axis_error_compensator (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .axi_i(axi), .axi_o(axo),
    .option_present_i(opt), .nc_axis_i(nc), .zero_established_i(zero),
    .pos_valid_i(pv), .pos_i(pp), .pitch_corr_i(pc), .pos_ready_o(pr),
    .out_valid_o(ov), .pos_o(po), .corr_o(co), .active_o(act));
  axis_feed_model u_axis_feed_model (.clk_i(clk_i), .ready_i(pr), .done_i(ov),
    .res_pos_i(po), .res_corr_i(co), .valid_o(pv), .pos_o(pp), .pitch_o(pc));

  function automatic logic [31:0] exp_corr(input logic [31:0] p);
    longint turn, r, t, i, rm, nx;
    turn = longint'(FULL_TURN_UNITS);
    r = longint'(signed'(p)) % turn;
    if (r < 0) r += turn;
    t = ((r * cc) % turn) * nd;
    i = t / turn;
    rm = t % turn;
    nx = (i + 1 == nd) ? 0 : i + 1;
    return 32'(tbl[i] + ((tbl[nx] - tbl[i]) * rm) / turn);
  endfunction : exp_corr

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    axi.awaddr <= 32'(a);
    axi.wdata <= d;
    axi.wstrb <= 4'hF;
    axi.awvalid <= 1'b1;
    axi.wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk_i);
      if (!aw_done && axo.awready === 1'b1) begin
        aw_done = 1'b1;
        axi.awvalid <= 1'b0;
      end
      if (!w_done && axo.wready === 1'b1) begin
        w_done = 1'b1;
        axi.wvalid <= 1'b0;
      end
    end
    do @(posedge clk_i); while (axo.bvalid !== 1'b1);
    r = axo.bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    axi.araddr <= 32'(a);
    axi.arvalid <= 1'b1;
    do @(posedge clk_i); while (axo.arready !== 1'b1);
    axi.arvalid <= 1'b0;
    do @(posedge clk_i); while (axo.rvalid !== 1'b1);
    d = axo.rdata;
    r = axo.rresp;
  endtask : axi_rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    `CHK("bresp", RESP_OKAY, r)
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    `CHK(nm, e, d)
  endtask : rd_chk

  task automatic cfg(input logic [31:0] st, input int n, input int c);
    wr(OFS_CTRL, 32'(CYC_ENABLE_ON));
    wr(OFS_ROTARY, 32'h1);
    wr(OFS_PITCH, 32'(ROT_PITCH));
    wr(OFS_ROT_DIV, 32'(ROT_DIV_A));
    wr(OFS_START, st);
    wr(OFS_NUM_DIV, 32'(n));
    wr(OFS_CYC_CONST, 32'(c));
    nd = n;
    cc = c;
  endtask : cfg

  task automatic run(input logic [31:0] p, input logic [31:0] ptc, input bit on);
    logic [31:0] rp, rc, e;
    e = on ? exp_corr(p) : 32'h0;
    u_axis_feed_model.send(2, p, ptc, rp, rc);
    `CHK("corr", e, rc)
    `CHK("pos", p + ptc + e, rp)
  endtask : run

  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask : tdone

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #200000;
    fails++;
    $display("[ERR] watchdog exp=done got=hang");
    tally_and_finish();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk(OFS_CTRL, 32'h0, "ctrl_rst");
    rd_chk(OFS_STATUS, 32'h0, "status_rst");
    axi_rd(12'h300, d, r);
    `CHK("rresp_unmapped", RESP_SLVERR, r)
    axi_wr(12'h300, 32'hFFFF_FFFF, r);
    `CHK("bresp_unmapped", RESP_SLVERR, r)
    wr(OFS_CORR, 32'h1234);
    rd_chk(OFS_CORR, 32'h0, "corr_ro");
    run(32'h0001_2345, 32'h7, 0);
    tdone("registers");
    cfg(32'h1069, 8, 256);
    for (int k = 0; k < 8; k++) begin
      tbl[k] = init_tbl[k];
      wr(OFS_TABLE + 12'(4 * k), 32'(init_tbl[k]));
    end
    rd_chk(OFS_TABLE + 12'h4, 32'hFFFF_FFFE, "entry_sext");
    rd_chk(OFS_STATUS, 32'h3, "status_on");
    `CHK("active_o", 1'b1, act)
    foreach (pos_list[k]) run(32'(pos_list[k]), 32'hFFFF_FFF9, 1);
    tdone("interpolation");
    wr(OFS_ROT_DIV, 32'h0);
    run(32'h7D0, 32'h0, 1);
    wr(OFS_PITCH, 32'h167);
    run(32'h7D0, 32'h0, 0);
    wr(OFS_PITCH, 32'h168);
    wr(OFS_ROTARY, 32'h0);
    run(32'h7D0, 32'h0, 0);
    wr(OFS_ROTARY, 32'h1);
    wr(OFS_CTRL, 32'h2);
    run(32'h7D0, 32'h0, 0);
    wr(OFS_CTRL, 32'h1);
    for (int k = 0; k < 3; k++) begin
      {opt, nc, zero} <= ~(3'h4 >> k);
      run(32'h7D0, 32'h0, 0);
    end
    {opt, nc, zero} <= 3'h7;
    tdone("enables");
    tbl[1] = 100;
    wr(OFS_TABLE + 12'h4, 32'h64);
    run(32'h7D0, 32'h0, 1);
    tdone("live_edit");
    wr(OFS_START, 32'h176B);
    wr(OFS_NUM_DIV, 32'h10);
    run(32'h7D0, 32'h0, 0);
    rd_chk(OFS_STATUS, 32'h0, "status_range");
    `CHK("active_o", 1'b0, act)
    cfg(32'h1768, 8, 256);
    run(32'h7D0, 32'h0, 1);
    cfg(32'hABE1, 8, 256);
    // Clock enable dropped mid-calculation; result must be unchanged
    fork
      run(32'h7D0, 32'h0, 1);
      begin
        repeat (40) @(posedge clk_i);
        ce_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        ce_i <= 1'b1;
      end
    join
    cfg(32'h1004, 8, 256);
    run(32'h7D0, 32'h0, 0);
    tdone("table_range");
    cfg(32'h1069, 128, 1);
    tbl[127] = 50;
    wr(OFS_TABLE_END, 32'h32);
    run(32'h0036_B792, 32'h3, 1);
    tdone("full_table");
    tally_and_finish();
  end
endmodule : cyclic_axis_error_compensator_tb
